//--- hw/sfi_pkg.sv
// Shared constants for the serial interface fault, interrupt and pin-control block
package sfi_pkg;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned BIT_W   = 3;
  localparam int unsigned HALF_W  = 4;
  localparam int unsigned DIV_W   = 6;
  // Master half-period lengths in system clocks, per baud select code
  localparam logic [5:0] DIV_SEL0 = 6'h01;
  localparam logic [5:0] DIV_SEL1 = 6'h04;
  localparam logic [5:0] DIV_SEL2 = 6'h08;
  localparam logic [5:0] DIV_SEL3 = 6'h10;
  localparam logic [3:0] HALF_LAST = 4'hf;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  // Reset values of control bits and data bytes
  localparam logic       RST_MASTER = 1'b1;
  localparam logic       RST_CLOCK_PHASE   = 1'b1;
  localparam logic       RST_OFF    = 1'b0;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  typedef enum logic [0:0] {MST_IDLE, MST_RUN} sfi_mst_e;
endpackage

//--- hw/sfi_core.sv
// Serial interface core: flags, mode fault, interrupts, resets, break, pins
`timescale 1ns/1ps
`default_nettype none
module sfi_core (
  input  wire logic       clk_sys_i,            // System clock, 100 MHz
  input  wire logic       sys_rst_i,            // Asynchronous reset, active high
  input  wire logic       ctrl_wr_i,            // Control register write strobe
  input  wire logic       module_enable_i,      // Written module enable
  input  wire logic       master_select_i,      // Written master select
  input  wire logic       clock_phase_i,        // Written clock phase
  input  wire logic       rx_irq_enable_i,      // Written receive interrupt enable
  input  wire logic       tx_irq_enable_i,      // Written transmit interrupt enable
  input  wire logic       scr_wr_i,             // Status/control register write strobe
  input  wire logic       mode_fault_enable_i,  // Written mode fault enable
  input  wire logic       error_irq_enable_i,   // Written error interrupt enable
  input  wire logic [1:0] baud_select_i,        // Written baud select pair
  input  wire logic       status_rd_i,          // Status register read strobe
  input  wire logic       data_rd_i,            // Receive data read strobe
  input  wire logic       data_wr_i,            // Transmit data write strobe
  input  wire logic [7:0] data_wr_data_i,       // Transmit data byte
  input  wire logic       debug_break_i,        // Debug break state level
  input  wire logic       break_clear_enable_i, // Allow flag clears in break
  input  wire logic       stop_mode_i,          // Stop mode level
  input  wire logic       ss_n_i,               // Slave select pin, active low
  input  wire logic       sck_link_i,           // Serial clock from a master
  input  wire logic       mosi_i,               // Data in pin (slave)
  input  wire logic       miso_i,               // Data in pin (master)
  output logic            miso_o,               // Slave data out
  output logic            miso_oe_o,            // Slave data out enable
  output logic            mosi_o,               // Master data out
  output logic            mosi_oe_o,            // Master data out enable
  output logic            sck_o,                // Master serial clock out
  output logic            sck_oe_o,             // Master serial clock enable
  output logic            port_override_o,      // Block owns pin directions
  output logic [7:0]      rx_data_o,            // Receive data register
  output logic            module_enable_o,      // Module enable state
  output logic            master_select_o,      // Master select state
  output logic            tx_empty_flag_o,      // Transmit empty flag
  output logic            rx_full_flag_o,       // Receive full flag
  output logic            overflow_flag_o,      // Overflow flag
  output logic            mode_fault_flag_o,    // Mode fault flag
  output logic            tx_irq_o,             // Transmit interrupt request
  output logic            rx_irq_o,             // Receive/error interrupt request
  output logic            wake_o                // Wakeup request for wait mode
);
  logic       en_reg, mst_reg, clock_phase_reg, rxie_reg, txie_reg, mfe_reg, error_irq_enable_reg;
  logic [1:0] baud_reg;
  logic       txe_reg, rxf_reg, ovf_reg, mf_reg;
  logic       rx_arm_reg, ov_arm_reg, mf_arm_reg;
  logic [7:0] tx_buf_reg, rx_data_reg, slv_byte_reg, mst_shift_reg;
  logic       ss_meta_reg, ss_sync_reg, ss_d_reg, mi_meta_reg, mi_sync_reg;
  logic       slv_en_reg, slv_active_reg;
  logic       dn_meta_reg, dn_sync_reg, dn_d_reg, act_meta_reg, act_sync_reg;
  logic [2:0] lk_cnt_reg, lk_idx_reg;
  logic [7:0] lk_shift_reg, lk_byte_reg;
  logic       lk_done_tgl_reg;
  sfi_pkg::sfi_mst_e mst_state_reg;
  logic [5:0] div_cnt_reg, div_len;
  logic [3:0] half_cnt_reg;
  logic       sck_reg, cap_reg, mst_done_reg;
  logic       frz, ss_rise, mst_fault, slv_fault, fault_now;
  logic       load_mst, load_slv, slv_done, byte_done, lk_rst;
  logic [7:0] byte_in;

  // Break freeze: flag clears and data writes are dropped
  assign frz       = debug_break_i & ~break_clear_enable_i;
  assign ss_rise   = ss_sync_reg & ~ss_d_reg;
  assign mst_fault = en_reg & mst_reg & mfe_reg & ~ss_sync_reg;
  // Phase 0 transfer runs from select low, phase 1 only once clocks came
  assign slv_fault = en_reg & ~mst_reg & mfe_reg & ss_rise &
                     (~clock_phase_reg | slv_active_reg);
  assign fault_now = mst_fault | slv_fault;
  assign slv_done  = dn_sync_reg ^ dn_d_reg;
  assign byte_done = mst_done_reg | (slv_done & slv_en_reg);
  assign byte_in   = mst_done_reg ? mst_shift_reg : lk_byte_reg;
  assign load_mst  = en_reg & mst_reg & ~txe_reg & ~stop_mode_i & (mst_state_reg == sfi_pkg::MST_IDLE);
  assign load_slv  = en_reg & ~mst_reg & ~txe_reg & ~slv_active_reg & (ss_sync_reg | clock_phase_reg);

  // Pin synchronisers; first stages feed only the second stages
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
      ss_d_reg    <= 1'b1;
      mi_meta_reg <= 1'b0;
      mi_sync_reg <= 1'b0;
    end else begin
      ss_meta_reg <= ss_n_i;
      ss_sync_reg <= ss_meta_reg;
      ss_d_reg    <= ss_sync_reg;
      mi_meta_reg <= miso_i;
      mi_sync_reg <= mi_meta_reg;
    end
  end

  // Control bits: loaded by system reset and register writes; master fault drops enable
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_reg    <= sfi_pkg::RST_OFF;
      mst_reg   <= sfi_pkg::RST_MASTER;
      clock_phase_reg  <= sfi_pkg::RST_CLOCK_PHASE;
      rxie_reg  <= sfi_pkg::RST_OFF;
      txie_reg  <= sfi_pkg::RST_OFF;
      mfe_reg   <= sfi_pkg::RST_OFF;
      error_irq_enable_reg <= sfi_pkg::RST_OFF;
      baud_reg  <= 2'h0;
    end else begin
      if (ctrl_wr_i) begin
        en_reg   <= module_enable_i;
        mst_reg  <= master_select_i;
        clock_phase_reg <= clock_phase_i;
        rxie_reg <= rx_irq_enable_i;
        txie_reg <= tx_irq_enable_i;
      end
      if (scr_wr_i) begin
        mfe_reg   <= mode_fault_enable_i;
        error_irq_enable_reg <= error_irq_enable_i;
        baud_reg  <= baud_select_i;
      end
      // Fault wins over a same-cycle enable write to protect the pins
      if (mst_fault)
        en_reg <= 1'b0;
    end
  end

  // Transmit buffer and empty flag
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      txe_reg    <= 1'b1;
      tx_buf_reg <= sfi_pkg::RST_BYTE;
    end else begin
      if (data_wr_i & ~frz) begin
        txe_reg    <= 1'b0;
        tx_buf_reg <= data_wr_data_i;
      end
      // Load or disable sets empty and wins over a racing write
      if (load_mst | load_slv | ~en_reg)
        txe_reg <= 1'b1;
    end
  end

  // Receive flags: overflow set wins over its clear; two-step clears armed by a status read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxf_reg     <= 1'b0;
      ovf_reg     <= 1'b0;
      rx_arm_reg  <= 1'b0;
      ov_arm_reg  <= 1'b0;
      rx_data_reg <= sfi_pkg::RST_BYTE;
    end else begin
      if (status_rd_i & ~frz) begin
        rx_arm_reg <= rxf_reg;
        ov_arm_reg <= ovf_reg;
      end
      if (data_rd_i & ~frz) begin
        if (rx_arm_reg) begin
          rxf_reg    <= 1'b0;
          rx_arm_reg <= 1'b0;
        end
        if (ov_arm_reg) begin
          ovf_reg    <= 1'b0;
          ov_arm_reg <= 1'b0;
        end
      end
      // An unread byte or pending overflow loses the new byte
      if (byte_done) begin
        if (rxf_reg | ovf_reg) begin
          ovf_reg <= 1'b1;
        end else begin
          rxf_reg     <= 1'b1;
          rx_data_reg <= byte_in;
        end
      end
    end
  end

  // Mode fault flag: clear needs read then control write with no fault present
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mf_reg     <= 1'b0;
      mf_arm_reg <= 1'b0;
    end else if (fault_now) begin
      mf_reg     <= 1'b1;
      mf_arm_reg <= 1'b0;
    end else begin
      if (status_rd_i & mf_reg & ~frz)
        mf_arm_reg <= 1'b1;
      if (ctrl_wr_i & mf_arm_reg & ~frz) begin
        mf_reg     <= 1'b0;
        mf_arm_reg <= 1'b0;
      end
    end
  end

  // Slave transfer tracking and byte handed to the slave shifter
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slv_en_reg     <= 1'b0;
      slv_active_reg <= 1'b0;
      slv_byte_reg   <= sfi_pkg::RST_BYTE;
      dn_meta_reg    <= 1'b0;
      dn_sync_reg    <= 1'b0;
      dn_d_reg       <= 1'b0;
      act_meta_reg   <= 1'b0;
      act_sync_reg   <= 1'b0;
    end else begin
      slv_en_reg     <= en_reg & ~mst_reg;
      slv_active_reg <= slv_en_reg & ~ss_sync_reg & act_sync_reg;
      dn_meta_reg    <= lk_done_tgl_reg;
      dn_sync_reg    <= dn_meta_reg;
      dn_d_reg       <= dn_sync_reg;
      act_meta_reg   <= (lk_cnt_reg != 3'h0);
      act_sync_reg   <= act_meta_reg;
      if (~en_reg)
        slv_byte_reg <= sfi_pkg::RST_BYTE;
      else if (load_slv)
        slv_byte_reg <= tx_buf_reg;
    end
  end

  // Link side resets while deselected or disabled, so mid-byte edges are dropped
  assign lk_rst = sys_rst_i | ss_n_i | ~slv_en_reg;
  // Link domain sampling on the rising serial clock edge
  always_ff @(posedge sck_link_i or posedge lk_rst) begin
    if (lk_rst) begin
      lk_cnt_reg   <= 3'h0;
      lk_shift_reg <= sfi_pkg::RST_BYTE;
    end else begin
      lk_cnt_reg   <= lk_cnt_reg + 3'h1;
      lk_shift_reg <= {lk_shift_reg[6:0], mosi_i};
    end
  end

  // Byte and toggle outlive deselect; resetting the toggle would post a false byte
  always_ff @(posedge sck_link_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lk_byte_reg     <= sfi_pkg::RST_BYTE;
      lk_done_tgl_reg <= 1'b0;
    end else if (lk_cnt_reg == sfi_pkg::BIT_LAST) begin
      lk_byte_reg     <= {lk_shift_reg[6:0], mosi_i};
      lk_done_tgl_reg <= ~lk_done_tgl_reg;
    end
  end

  // Link domain output bit index advances on the falling edge
  always_ff @(negedge sck_link_i or posedge lk_rst) begin
    if (lk_rst)
      lk_idx_reg <= 3'h0;
    else
      lk_idx_reg <= lk_idx_reg + 3'h1;
  end

  // Master half-period length from the baud select pair
  always_comb begin
    unique case (baud_reg)
      2'h0: div_len = sfi_pkg::DIV_SEL0;
      2'h1: div_len = sfi_pkg::DIV_SEL1;
      2'h2: div_len = sfi_pkg::DIV_SEL2;
      2'h3: div_len = sfi_pkg::DIV_SEL3;
    endcase
  end

  // Master engine; stop mode freezes it with all state kept
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mst_state_reg <= sfi_pkg::MST_IDLE;
      div_cnt_reg   <= 6'h00;
      half_cnt_reg  <= 4'h0;
      sck_reg       <= 1'b0;
      cap_reg       <= 1'b0;
      mst_shift_reg <= sfi_pkg::RST_BYTE;
      mst_done_reg  <= 1'b0;
    end else if (~en_reg) begin
      mst_state_reg <= sfi_pkg::MST_IDLE;
      div_cnt_reg   <= 6'h00;
      half_cnt_reg  <= 4'h0;
      sck_reg       <= 1'b0;
      mst_shift_reg <= sfi_pkg::RST_BYTE;
      mst_done_reg  <= 1'b0;
    end else begin
      mst_done_reg <= 1'b0;
      unique case (mst_state_reg)
        sfi_pkg::MST_IDLE: begin
          if (load_mst) begin
            mst_shift_reg <= tx_buf_reg;
            div_cnt_reg   <= div_len - 6'h01;
            half_cnt_reg  <= 4'h0;
            mst_state_reg <= sfi_pkg::MST_RUN;
          end
        end
        sfi_pkg::MST_RUN: begin
          if (div_cnt_reg != 6'h00) begin
            div_cnt_reg <= div_cnt_reg - {5'h00, ~stop_mode_i};
          end else if (~stop_mode_i) begin
            div_cnt_reg  <= div_len - 6'h01;
            sck_reg      <= ~sck_reg;
            half_cnt_reg <= half_cnt_reg + 4'h1;
            if (~sck_reg)
              cap_reg <= mi_sync_reg;
            else
              mst_shift_reg <= {mst_shift_reg[6:0], cap_reg};
            if (half_cnt_reg == sfi_pkg::HALF_LAST) begin
              mst_state_reg <= sfi_pkg::MST_IDLE;
              mst_done_reg  <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Pin direction and data; disabled block hands pins back to the port
  assign port_override_o = en_reg;
  assign sck_oe_o        = en_reg & mst_reg;
  assign mosi_oe_o       = en_reg & mst_reg;
  assign miso_oe_o       = en_reg & ~mst_reg & ~ss_sync_reg;
  assign sck_o           = sck_reg;
  assign mosi_o          = mst_shift_reg[7];
  assign miso_o          = slv_byte_reg[~lk_idx_reg];

  // Interrupt requests; receive/error is one shared line
  assign tx_irq_o = txe_reg & txie_reg & en_reg;
  assign rx_irq_o = (rxf_reg & rxie_reg) | (error_irq_enable_reg & (ovf_reg | mf_reg));
  assign wake_o   = tx_irq_o | rx_irq_o;

  // Register-backed status outputs
  assign rx_data_o         = rx_data_reg;
  assign module_enable_o   = en_reg;
  assign master_select_o   = mst_reg;
  assign tx_empty_flag_o   = txe_reg;
  assign rx_full_flag_o    = rxf_reg;
  assign overflow_flag_o   = ovf_reg;
  assign mode_fault_flag_o = mf_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_MODE_FAULT_FLAG_PHASE0: assert property (ss_rise && slv_en_reg && en_reg && mfe_reg && !clock_phase_reg |=> mf_reg)
    else $error("phase 0 deselect did not raise mode fault");
  AST_NO_MODE_FAULT_FLAG_PHASE1: assert property (ss_rise && clock_phase_reg && !slv_active_reg && !mst_reg && !mf_reg |=> !mf_reg)
    else $error("phase 1 idle select raised mode fault");
  AST_SLAVE_MODE_FAULT_FLAG_KEEPS_EN: assert property (slv_fault && !ctrl_wr_i |=> en_reg)
    else $error("slave mode fault changed module enable");
  AST_MISO_FLOAT: assert property (ss_sync_reg |-> !miso_oe_o)
    else $error("slave output driven while deselected");
  AST_MODE_FAULT_FLAG_CLEAR_PATH: assert property ($fell(mf_reg) |-> $past(ctrl_wr_i && mf_arm_reg && !fault_now))
    else $error("mode fault cleared without read then control write");
  AST_TX_IRQ_NEEDS_EN: assert property (tx_irq_o |-> en_reg && txe_reg)
    else $error("transmit interrupt without enable");
  AST_RX_IRQ_NO_EN: assert property (rxf_reg && rxie_reg && !en_reg |-> rx_irq_o)
    else $error("receive interrupt gated by module enable");
  AST_MODE_FAULT_FLAG_NEEDS_MFE: assert property (!mfe_reg && !mf_reg |=> !mf_reg)
    else $error("mode fault set with detection off");
  AST_RXF_CLEAR_PATH: assert property ($fell(rxf_reg) |-> $past(data_rd_i && rx_arm_reg))
    else $error("receive full cleared without read pair");
  AST_TXE_ONLY_BY_WRITE: assert property ($fell(txe_reg) |-> $past(data_wr_i && !frz))
    else $error("transmit empty cleared without a data write");
  AST_TXE_SET_ON_LOAD: assert property (load_mst || load_slv |=> txe_reg)
    else $error("load into shifter left transmit empty low");
  AST_DISABLED_STATE: assert property (!en_reg |=> txe_reg && mst_state_reg == sfi_pkg::MST_IDLE && !sck_o)
    else $error("disabled block not in partial reset");
  AST_MASTER_FAULT_DROPS_EN: assert property (mst_fault |=> !en_reg && mf_reg ##1 !sck_oe_o)
    else $error("master fault left module enabled");
  AST_BREAK_FREEZE: assert property (frz |=> !$fell(rxf_reg) && !$fell(ovf_reg) && !$fell(mf_reg))
    else $error("flag cleared during protected break");
  AST_BREAK_WRITE_IGNORED: assert property (frz && data_wr_i && txe_reg && en_reg |=> txe_reg)
    else $error("data write during break took effect");

  COV_RX_BYTE: cover property (byte_done && !rxf_reg ##1 rxf_reg);
  COV_OVERFLOW: cover property (byte_done && rxf_reg ##1 ovf_reg);
  COV_SLAVE_FAULT: cover property (slv_fault ##1 mf_reg);
  COV_MASTER_FAULT: cover property (mst_fault ##1 !en_reg);
endmodule
`default_nettype wire

//--- test/sfi_peer.sv
// Far-side model: a link master for slave tests and a link slave for master tests
`timescale 1ns/1ps
`default_nettype none
module sfi_peer (
  input  wire logic m_sck_i,   // Serial clock from the block as master
  input  wire logic m_mosi_i,  // Data from the block as master
  input  wire logic s_miso_i,  // Data from the block as slave
  output logic      ss_n_o,    // Slave select, active low
  output logic      sck_o,     // Link clock, still outside frames
  output logic      mosi_o,    // Data to the block as slave
  output logic      miso_o     // Data to the block as master
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  initial begin
    ss_n_o = 1'b1;
    sck_o  = 1'b0;
    mosi_o = 1'b0;
    tx_sh  = 8'h00;
  end
  // Slave side: capture on rise, shift out MSB first on fall
  always @(posedge m_sck_i) rx_sh <= {rx_sh[6:0], m_mosi_i};
  always @(negedge m_sck_i) tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
  assign miso_o = tx_sh[7];
  // Master side: n bits at 30 ns, MSB first, select held across the frame
  task automatic frame(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    ss_n_o = 1'b0;
    #100;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = b[i];
      #15 sck_o = 1'b1;
      r[i] = s_miso_i;
      #15 sck_o = 1'b0;
    end
    #60 ss_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line must not keep the last bit
  endtask
endmodule
`default_nettype wire

//--- test/sfi_core_tb.sv
// Self-checking bench for the serial interface fault and pin block
`timescale 1ns/1ps
`default_nettype none
module sfi_core_tb;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ctrl_wr_i, module_enable_i, master_select_i, clock_phase_i, rx_irq_enable_i, tx_irq_enable_i;
  logic scr_wr_i, mode_fault_enable_i, error_irq_enable_i, status_rd_i, data_rd_i, data_wr_i;
  logic debug_break_i, break_clear_enable_i, stop_mode_i;
  logic [1:0] baud_select_i;
  logic [7:0] data_wr_data_i, rx_data_o, r;
  wire  ss_n_i, sck_link_i, mosi_i, miso_i;
  logic miso_o, miso_oe_o, mosi_o, mosi_oe_o, sck_o, sck_oe_o, port_override_o, module_enable_o;
  logic master_select_o, tx_empty_flag_o, rx_full_flag_o, overflow_flag_o, mode_fault_flag_o;
  logic tx_irq_o, rx_irq_o, wake_o;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sfi_core sfi_core_i (.clk_sys_i, .sys_rst_i, .ctrl_wr_i, .module_enable_i, .master_select_i,
    .clock_phase_i, .rx_irq_enable_i, .tx_irq_enable_i, .scr_wr_i, .mode_fault_enable_i,
    .error_irq_enable_i, .baud_select_i, .status_rd_i, .data_rd_i, .data_wr_i, .data_wr_data_i,
    .debug_break_i, .break_clear_enable_i, .stop_mode_i, .ss_n_i, .sck_link_i, .mosi_i, .miso_i,
    .miso_o, .miso_oe_o, .mosi_o, .mosi_oe_o, .sck_o, .sck_oe_o, .port_override_o, .rx_data_o,
    .module_enable_o, .master_select_o, .tx_empty_flag_o, .rx_full_flag_o, .overflow_flag_o,
    .mode_fault_flag_o, .tx_irq_o, .rx_irq_o, .wake_o);
  sfi_peer sfi_peer_i (.m_sck_i(sck_o), .m_mosi_i(mosi_o), .s_miso_i(miso_o), .ss_n_o(ss_n_i),
    .sck_o(sck_link_i), .mosi_o(mosi_i), .miso_o(miso_i));
  // Compare and count; unknowns never match
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Control write: enable, master, phase, rx irq, tx irq
  task automatic ctl(input logic [4:0] v);
    @(posedge clk_sys_i);
    {module_enable_i, master_select_i, clock_phase_i, rx_irq_enable_i, tx_irq_enable_i} <= v;
    ctrl_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    ctrl_wr_i <= 1'b0;
  endtask
  // One-cycle strobe: 0 status read, 1 data read, 2 data write, 3 status/control write
  task automatic stb(input int k);
    @(posedge clk_sys_i);
    case (k)
      0: status_rd_i <= 1'b1;
      1: data_rd_i <= 1'b1;
      2: data_wr_i <= 1'b1;
      default: scr_wr_i <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    {status_rd_i, data_rd_i, data_wr_i, scr_wr_i} <= 4'h0;
  endtask
  task automatic brk(input logic b, input logic ce);
    @(posedge clk_sys_i);
    debug_break_i <= b;
    break_clear_enable_i <= ce;
  endtask
  // Bounded wait for a received byte; slow baud keeps the frame near 256 cycles
  task automatic wait_rx();
    int k;
    k = 0;
    while (rx_full_flag_o !== 1'b1 && k < 3000) begin
      @(posedge clk_sys_i);
      k++;
    end
    #1;
    chk(rx_full_flag_o, 8'h01);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well above the sum of all frames and waits
  initial begin
    #600000;
    n_fail++;
    final_report();
  end
  initial begin
    {ctrl_wr_i, module_enable_i, master_select_i, clock_phase_i, rx_irq_enable_i, tx_irq_enable_i} = '0;
    {scr_wr_i, mode_fault_enable_i, error_irq_enable_i, status_rd_i, data_rd_i, data_wr_i} = '0;
    {debug_break_i, break_clear_enable_i, stop_mode_i} = '0;
    baud_select_i = 2'h0;
    data_wr_data_i = 8'h00;
    cyc(2);
    sys_rst_i <= 1'b0;
    cyc(1);
    chk({tx_empty_flag_o, rx_full_flag_o, mode_fault_flag_o, module_enable_o}, 8'h08);
    chk({master_select_o, tx_irq_o, rx_irq_o, miso_oe_o, port_override_o}, 8'h10);
    $display("test reset done");
    // Master byte exchange at the slowest baud
    {mode_fault_enable_i, error_irq_enable_i, baud_select_i} <= 4'h7;
    stb(3);
    ctl(5'h19);
    cyc(2);
    chk({port_override_o, sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h0e);
    chk({tx_irq_o, wake_o}, 8'h03);
    sfi_peer_i.tx_sh = 8'ha5;
    data_wr_data_i <= 8'h3c;
    stb(2);
    wait_rx();
    chk(rx_data_o, 8'ha5);
    chk(sfi_peer_i.rx_sh, 8'h3c);
    chk({tx_empty_flag_o, rx_irq_o}, 8'h02);
    ctl(5'h1b);
    cyc(2);
    chk(rx_irq_o, 8'h01);
    ctl(5'h0b);
    cyc(2);
    chk({rx_irq_o, tx_irq_o, rx_full_flag_o, tx_empty_flag_o}, 8'h0b);
    chk({port_override_o, sck_oe_o, mosi_oe_o}, 8'h00);
    stb(1);
    cyc(2);
    chk(rx_full_flag_o, 8'h01);
    stb(0);
    brk(1'b1, 1'b0);
    stb(1);
    cyc(2);
    chk(rx_full_flag_o, 8'h01);
    brk(1'b0, 1'b0);
    stb(1);
    cyc(2);
    chk(rx_full_flag_o, 8'h00);
    $display("test master done");
    // Data write in break with clears locked
    ctl(5'h19);
    brk(1'b1, 1'b0);
    data_wr_data_i <= 8'hff;
    stb(2);
    cyc(600);
    chk({tx_empty_flag_o, rx_full_flag_o}, 8'h02);
    brk(1'b0, 1'b0);
    $display("test break done");
    // Stop mid-frame freezes the master; a frame would end well inside 300 cycles
    data_wr_data_i <= 8'h81;
    stb(2);
    cyc(40);
    stop_mode_i <= 1'b1;
    cyc(2);
    r = {7'h00, sck_o};
    cyc(300);
    chk(sck_o, r);
    chk({tx_empty_flag_o, rx_full_flag_o, module_enable_o, sck_oe_o}, 8'h0b);
    // Leaving stop through reset aborts the frame and resets the block
    sys_rst_i <= 1'b1;
    cyc(2);
    sys_rst_i <= 1'b0;
    stop_mode_i <= 1'b0;
    cyc(2);
    chk({module_enable_o, sck_o, tx_empty_flag_o, rx_full_flag_o}, 8'h02);
    ctl(5'h19);
    $display("test stop done");
    // Master sees select low
    {mode_fault_enable_i, error_irq_enable_i, baud_select_i} <= 4'hf;
    stb(3);
    sfi_peer_i.ss_n_o = 1'b0;
    cyc(6);
    chk({mode_fault_flag_o, module_enable_o, tx_empty_flag_o, rx_irq_o}, 8'h0b);
    chk({sck_oe_o, mosi_oe_o, port_override_o}, 8'h00);
    sfi_peer_i.ss_n_o = 1'b1;
    cyc(4);
    stb(0);
    ctl(5'h09);
    cyc(2);
    chk(mode_fault_flag_o, 8'h00);
    $display("test master fault done");
    // Slave select without clocks, both phases
    ctl(5'h16);
    sfi_peer_i.ss_n_o = 1'b0;
    cyc(6);
    chk({miso_oe_o, mosi_oe_o, sck_oe_o}, 8'h04);
    sfi_peer_i.ss_n_o = 1'b1;
    cyc(6);
    chk({mode_fault_flag_o, miso_oe_o}, 8'h00);
    ctl(5'h12);
    sfi_peer_i.ss_n_o = 1'b0;
    cyc(6);
    sfi_peer_i.ss_n_o = 1'b1;
    cyc(6);
    chk({mode_fault_flag_o, module_enable_o, rx_irq_o}, 8'h07);
    stb(0);
    ctl(5'h16);
    cyc(2);
    chk(mode_fault_flag_o, 8'h00);
    $display("test slave select done");
    // Slave: aborted byte, then a whole one; the queued byte goes out MSB first
    data_wr_data_i <= 8'h5a;
    stb(2);
    cyc(4);
    chk(tx_empty_flag_o, 8'h01);
    sfi_peer_i.frame(8'h3f, 3, r);
    chk(r, 8'h40);
    cyc(6);
    chk(mode_fault_flag_o, 8'h01);
    stb(0);
    ctl(5'h16);
    cyc(2);
    sfi_peer_i.frame(8'h96, 8, r);
    chk(r, 8'h5a);
    wait_rx();
    chk(rx_data_o, 8'h96);
    cyc(6);
    chk(overflow_flag_o, 8'h00);
    brk(1'b1, 1'b1);
    stb(0);
    stb(1);
    brk(1'b0, 1'b0);
    cyc(2);
    chk(rx_full_flag_o, 8'h00);
    $display("test slave done");
    final_report();
  end
endmodule
`default_nettype wire
